// ===== shift_branch_break_exec.sv
// The placing of the registers and the AXI4-Lite slave port were left to the implementer.
`default_nettype none
module shift_branch_break_exec
  import exec_pkg::*;
(
  // clock and reset
  input  wire logic        core_clk_i,
  input  wire logic        rst_n_i,
  // memory bus (one access per cycle, read data in the strobe cycle)
  output logic [15:0]      mem_addr_o,
  output logic             mem_rd_o,
  output logic             mem_wr_o,
  output logic [7:0]       mem_wdata_o,
  input  wire logic [7:0]  mem_rdata_i,
  // axi4-lite write
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  // axi4-lite read
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready
);
  import exec_pkg::*;
  // ****************************************
  // core state
  // ****************************************
  state_e      st_q;
  logic [15:0] pc_q;
  logic [7:0]  acc_q, ps_q, sp_q, op_q, opr_q, zpa_q;
  logic        run_q;
  wire         is_branch, is_bit_br, is_zp_bit, taken;
  // memory operand was parked in opr_q; the bus carries the offset by then
  wire  [7:0]  test_val = is_zp_bit ? opr_q : acc_q;
  branch_cond u_cond (
    .opcode_i    (op_q),
    .ps_i        (ps_q),
    .operand_i   (test_val),
    .is_branch_o (is_branch),
    .is_bit_br_o (is_bit_br),
    .is_zp_bit_o (is_zp_bit),
    .taken_o     (taken)
  );
  // sign-extended relative target from the byte just read
  wire  [15:0] rel_tgt  = pc_q + {{8{mem_rdata_i[7]}}, mem_rdata_i};
  wire  [7:0]  shl_src  = (op_q == OP_SHL_A) ? acc_q : mem_rdata_i;
  wire  [7:0]  shl_res  = {shl_src[6:0], 1'b0};
  wire  [7:0]  and_res  = acc_q & mem_rdata_i;
  wire  [15:0] sp_addr  = {STACK_PAGE, sp_q};
  // ****************************************
  // axi4-lite slave
  // ****************************************
  logic        aw_q, w_q;
  logic [7:0]  awa_q;
  logic [31:0] wd_q;
  wire         do_wr = aw_q && w_q && !s_axi_bvalid;
  wire         ctrl_wr = do_wr && (awa_q == REG_CTRL) && wd_q[0] == 1'b1 ? 1'b1 : 1'b0;
  wire         ctrl_clr = do_wr && (awa_q == REG_CTRL) && !wd_q[0];
  wire         map_ok = (awa_q == REG_CTRL);
  wire  [31:0] rd_mux = (s_axi_araddr == REG_CTRL) ? {31'h0, run_q} :
                        (s_axi_araddr == REG_STAT) ? {16'h0, sp_q, ps_q} :
                        (s_axi_araddr == REG_PC)   ? {16'h0, pc_q} :
                        (s_axi_araddr == REG_ACC)  ? {24'h0, acc_q} : 32'h0;
  wire         rd_ok = (s_axi_araddr == REG_CTRL) || (s_axi_araddr == REG_STAT) ||
                       (s_axi_araddr == REG_PC) || (s_axi_araddr == REG_ACC);
  always_ff @(posedge core_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      aw_q <= 1'b0; w_q <= 1'b0; awa_q <= 8'h00; wd_q <= 32'h0;
      s_axi_awready <= 1'b1; s_axi_wready <= 1'b1;
      s_axi_bvalid <= 1'b0; s_axi_bresp <= RESP_OK;
      s_axi_arready <= 1'b1; s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0; s_axi_rresp <= RESP_OK;
      run_q <= 1'b0;
    end
    else
    begin
      if (s_axi_awvalid && s_axi_awready)
      begin
        aw_q <= 1'b1; awa_q <= s_axi_awaddr; s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        w_q <= 1'b1; wd_q <= s_axi_wdata; s_axi_wready <= 1'b0;
      end
      if (do_wr)
      begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= map_ok ? RESP_OK : RESP_ERR;
        if (ctrl_wr) run_q <= 1'b1;
        if (ctrl_clr) run_q <= 1'b0;
      end
      if (s_axi_bvalid && s_axi_bready)
      begin
        s_axi_bvalid <= 1'b0; aw_q <= 1'b0; w_q <= 1'b0;
        s_axi_awready <= 1'b1; s_axi_wready <= 1'b1;
      end
      if (s_axi_arvalid && s_axi_arready)
      begin
        s_axi_arready <= 1'b0; s_axi_rvalid <= 1'b1;
        s_axi_rdata <= rd_mux; s_axi_rresp <= rd_ok ? RESP_OK : RESP_ERR;
      end
      if (s_axi_rvalid && s_axi_rready)
      begin
        s_axi_rvalid <= 1'b0; s_axi_arready <= 1'b1;
      end
    end
  end
  // ****************************************
  // execution sequencer
  // ****************************************
  always_ff @(posedge core_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      st_q <= ST_HALT; pc_q <= RESET_PC; acc_q <= 8'h00; ps_q <= PS_RESET;
      sp_q <= SP_RESET; op_q <= 8'h00; opr_q <= 8'h00; zpa_q <= 8'h00;
      mem_addr_o <= 16'h0000; mem_rd_o <= 1'b0; mem_wr_o <= 1'b0; mem_wdata_o <= 8'h00;
    end
    else
    begin
      mem_rd_o <= 1'b0;
      mem_wr_o <= 1'b0;
      case (st_q)
        ST_HALT:
          if (run_q)
          begin
            mem_addr_o <= pc_q; mem_rd_o <= 1'b1; st_q <= ST_FETCH;
          end
        ST_FETCH:
        begin
          op_q <= mem_rdata_i;
          pc_q <= pc_q + 16'h0001;
          if (mem_rdata_i == OP_SHL_A)
          begin
            st_q <= ST_WB;
          end
          else if (mem_rdata_i == OP_SWI)
          begin
            ps_q[FLAG_B] <= 1'b1;
            pc_q <= pc_q + 16'h0002;
            st_q <= ST_PUSH_H;
          end
          else
          begin
            mem_addr_o <= pc_q + 16'h0001; mem_rd_o <= 1'b1; st_q <= ST_OPER;
          end
        end
        ST_OPER:
        begin
          pc_q <= pc_q + 16'h0001;
          opr_q <= mem_rdata_i;
          if (is_branch && !(is_bit_br && is_zp_bit))
          begin
            // offset byte read again so the target stage sees it on the bus
            mem_addr_o <= pc_q; mem_rd_o <= 1'b1; st_q <= ST_TGT;
          end
          else
          begin
            zpa_q <= mem_rdata_i;
            mem_addr_o <= {8'h00, mem_rdata_i}; mem_rd_o <= 1'b1; st_q <= ST_MEMRD;
          end
        end
        ST_MEMRD:
          if (is_bit_br)
          begin
            opr_q <= mem_rdata_i;
            mem_addr_o <= pc_q; mem_rd_o <= 1'b1; st_q <= ST_TGT;
          end
          else
          begin
            if (op_q == OP_TEST_ZP)
            begin
              ps_q[FLAG_N] <= mem_rdata_i[7]; ps_q[FLAG_V] <= mem_rdata_i[6];
              ps_q[FLAG_Z] <= (and_res == 8'h00);
            end
            else if (op_q == OP_SHL_ZP)
            begin
              mem_addr_o <= {8'h00, zpa_q}; mem_wr_o <= 1'b1; mem_wdata_o <= shl_res;
              ps_q[FLAG_C] <= mem_rdata_i[7]; ps_q[FLAG_N] <= shl_res[7];
              ps_q[FLAG_Z] <= (shl_res == 8'h00);
            end
            st_q <= ST_HALT;
          end
        ST_TGT:
        begin
          // relative offset counts from the byte after the instruction
          if (is_bit_br && is_zp_bit) pc_q <= pc_q + 16'h0001;
          if (taken) pc_q <= rel_tgt + (is_bit_br && is_zp_bit ? 16'h0001 : 16'h0000);
          // untaken: only the pc steps past the operands
          st_q <= ST_HALT;
        end
        ST_WB:
          // break borrows this slot to take the vector high byte
          if (op_q == OP_SWI)
          begin
            pc_q[15:8] <= mem_rdata_i;
            st_q <= ST_HALT;
          end
          else
          begin
            acc_q <= shl_res; ps_q[FLAG_C] <= acc_q[7];
            ps_q[FLAG_N] <= shl_res[7]; ps_q[FLAG_Z] <= (shl_res == 8'h00);
            st_q <= ST_HALT;
          end
        ST_PUSH_H:
        begin
          mem_addr_o <= sp_addr; mem_wr_o <= 1'b1; mem_wdata_o <= pc_q[15:8];
          sp_q <= sp_q - 8'h01; st_q <= ST_PUSH_L;
        end
        ST_PUSH_L:
        begin
          mem_addr_o <= sp_addr; mem_wr_o <= 1'b1; mem_wdata_o <= pc_q[7:0];
          sp_q <= sp_q - 8'h01; st_q <= ST_PUSH_S;
        end
        ST_PUSH_S:
        begin
          mem_addr_o <= sp_addr; mem_wr_o <= 1'b1; mem_wdata_o <= ps_q;
          sp_q <= sp_q - 8'h01; st_q <= ST_VEC_L;
        end
        ST_VEC_L:
        begin
          mem_addr_o <= SWI_VEC; mem_rd_o <= 1'b1; st_q <= ST_VEC_H;
        end
        ST_VEC_H:
        begin
          pc_q[7:0] <= mem_rdata_i;
          mem_addr_o <= SWI_VEC + 16'h0001; mem_rd_o <= 1'b1; st_q <= ST_WB;
        end
        default: st_q <= ST_HALT;
      endcase
    end
  end
endmodule // shift_branch_break_exec
`default_nettype wire

// ===== exec_pkg.sv
// Function
// - left shift moves operand up, zero into bit 0, old bit 7 to carry
// - bit-test branches jump when selected bit is clear or set
// - carry branches jump only when carry is 0 or 1 respectively
// - zero branches jump when zero is 1 (equal) or 0 (not equal)
// - sign branches jump when negative is 1 (minus) or 0 (plus)
// - test ands accumulator with memory and stores nothing
// - branch always adds signed offset to the program counter
// - software interrupt sets break, pushes pc high, pc low, status, loads vector
`default_nettype none
package exec_pkg;
  // ****************************************
  // opcodes
  // ****************************************
  localparam logic [7:0] OP_SHL_A   = 8'h0a;
  localparam logic [7:0] OP_SHL_ZP  = 8'h06;
  localparam logic [7:0] OP_TEST_ZP = 8'h24;
  localparam logic [7:0] OP_SWI     = 8'h00;
  localparam logic [7:0] OP_BCLO    = 8'h90;
  localparam logic [7:0] OP_BCHI    = 8'hb0;
  localparam logic [7:0] OP_BEQ_Z   = 8'hf0;
  localparam logic [7:0] OP_BNE_Z   = 8'hd0;
  localparam logic [7:0] OP_BMINUS  = 8'h30;
  localparam logic [7:0] OP_BPLUS   = 8'h10;
  localparam logic [7:0] OP_BALWAYS = 8'h80;
  // bit branch: low nibble 3/7 set-test, same nibble with bit 4 set for clear-test, bits 7:5 = index
  localparam logic [3:0] BB_SET_A   = 4'h3;
  localparam logic [3:0] BB_SET_ZP  = 4'h7;
  localparam logic [3:0] BB_CLR_A   = 4'h3;
  localparam logic [3:0] BB_CLR_ZP  = 4'h7;
  localparam logic       BB_CLR_SEL = 1'b1;
  // ****************************************
  // status bits and vectors
  // ****************************************
  localparam int         FLAG_C     = 0;
  localparam int         FLAG_Z     = 1;
  localparam int         FLAG_B     = 4;
  localparam int         FLAG_N     = 7;
  localparam int         FLAG_V     = 6;
  localparam logic [7:0] STACK_PAGE = 8'h01;
  localparam logic [7:0] SP_RESET   = 8'hff;
  localparam logic [7:0] PS_RESET   = 8'h04;
  localparam logic [15:0] SWI_VEC   = 16'hfff4;
  localparam logic [15:0] RESET_PC  = 16'h0000;
  // ****************************************
  // register map (axi4-lite, byte offsets)
  // ****************************************
  localparam logic [7:0] REG_CTRL   = 8'h00;
  localparam logic [7:0] REG_STAT   = 8'h04;
  localparam logic [7:0] REG_PC     = 8'h08;
  localparam logic [7:0] REG_ACC    = 8'h0c;
  localparam logic [1:0] RESP_OK    = 2'b00;
  localparam logic [1:0] RESP_ERR   = 2'b10;
  typedef enum logic [3:0] {
    ST_HALT, ST_FETCH, ST_OPER, ST_MEMRD, ST_TGT, ST_WB,
    ST_PUSH_H, ST_PUSH_L, ST_PUSH_S, ST_VEC_L, ST_VEC_H
  } state_e;
endpackage
`default_nettype wire

// ===== branch_cond.sv
`default_nettype none
// ****************************************
// branch condition decode
// ****************************************
module branch_cond
  import exec_pkg::*;
(
  // decode in
  input  wire logic [7:0] opcode_i,
  input  wire logic [7:0] ps_i,
  input  wire logic [7:0] operand_i,
  // result
  output logic            is_branch_o,
  output logic            is_bit_br_o,
  output logic            is_zp_bit_o,
  output logic            taken_o
);
  wire       bb_set  = (opcode_i[3:0] == BB_SET_A) || (opcode_i[3:0] == BB_SET_ZP);
  wire       bb_clr  = opcode_i[4] == BB_CLR_SEL;
  wire [2:0] bb_idx  = opcode_i[7:5];
  wire       sel_bit = operand_i[bb_idx];
  always_comb
  begin
    is_branch_o = 1'b1;
    is_bit_br_o = 1'b0;
    is_zp_bit_o = opcode_i[2];
    taken_o     = 1'b0;
    if (bb_set)
    begin
      is_bit_br_o = 1'b1;
      taken_o     = bb_clr ? !sel_bit : sel_bit;
    end
    else
      case (opcode_i)
        OP_BCLO:    taken_o = !ps_i[FLAG_C];
        OP_BCHI:    taken_o = ps_i[FLAG_C];
        OP_BEQ_Z:   taken_o = ps_i[FLAG_Z];
        OP_BNE_Z:   taken_o = !ps_i[FLAG_Z];
        OP_BMINUS:  taken_o = ps_i[FLAG_N];
        OP_BPLUS:   taken_o = !ps_i[FLAG_N];
        OP_BALWAYS: taken_o = 1'b1;
        default:    is_branch_o = 1'b0;
      endcase
  end
endmodule // branch_cond
`default_nettype wire

// ===== exec_properties.sv
`default_nettype none
// ********************************
// port checker
// ********************************
module exec_properties
  import exec_pkg::*;
(
  // clock and reset
  input wire logic        core_clk_i,
  input wire logic        rst_n_i,
  // memory bus
  input wire logic [15:0] mem_addr_o,
  input wire logic        mem_rd_o,
  input wire logic        mem_wr_o,
  input wire logic [7:0]  mem_wdata_o,
  input wire logic [7:0]  mem_rdata_i,
  // axi4-lite
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready
);
  logic [7:0]  rdat_q;
  logic [7:0]  wdat_q;
  logic [15:0] wadr_q;
  // no reset: only read where a write or read has gone before
  always_ff @(posedge core_clk_i)
  begin
    if (mem_rd_o) rdat_q <= mem_rdata_i;
    if (mem_wr_o) wadr_q <= mem_addr_o;
    if (mem_wr_o) wdat_q <= mem_wdata_o;
  end
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (!rst_n_i);
  sequence vec_lo; mem_rd_o && mem_addr_o == SWI_VEC; endsequence
  sequence vec_hi; mem_rd_o && mem_addr_o == SWI_VEC + 16'h1; endsequence
  a_one_access:
    assert property (!(mem_rd_o && mem_wr_o)) else $error("read and write together");
  a_shift_store:
    assert property (mem_wr_o && mem_addr_o[15:8] == 8'h00 |-> mem_wdata_o == {rdat_q[6:0], 1'b0})
    else $error("shifted store wrong");
  a_break_push:
    assert property (vec_lo |-> wadr_q[15:8] == STACK_PAGE && wdat_q[FLAG_B])
    else $error("status not pushed with break set");
  a_vector_order:
    assert property (vec_lo |-> ##[1:4] vec_hi) else $error("vector high byte missing");
  a_b_hold:
    assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid) else $error("bvalid dropped");
  a_b_release:
    assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid) else $error("bvalid stuck");
  a_r_answer:
    assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid) else $error("no read answer");
  a_r_hold:
    assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read answer changed");
endmodule // exec_properties
bind shift_branch_break_exec exec_properties u_props (
  .core_clk_i, .rst_n_i, .mem_addr_o, .mem_rd_o, .mem_wr_o, .mem_wdata_o, .mem_rdata_i,
  .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rvalid, .s_axi_rready
);
`default_nettype wire

// ===== mem_model.sv
`default_nettype none
// ********************************
// program and data memory
// ********************************
module mem_model (
  // core bus
  input  wire logic        clk_i,
  input  wire logic [15:0] addr_i,
  input  wire logic        rd_i,
  input  wire logic        wr_i,
  input  wire logic [7:0]  wdata_i,
  output var logic [7:0]   rdata_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] mem [0:65535];
  logic [7:0] last_q;
  initial
  begin
    foreach (mem[i]) mem[i] = 8'hea;
    last_q = 8'h00;
  end
  // a read answers within the cycle of its strobe, as the core samples it at the next edge
  // idle bus shows the inverted last byte, so a late sample cannot pass
  assign rdata_o = rd_i ? mem[addr_i] : last_q;
  always @(posedge clk_i)
  begin
    if (wr_i) mem[addr_i] <= wdata_i;
    if (rd_i) last_q <= ~mem[addr_i];
  end
endmodule // mem_model
`default_nettype wire

// ===== tb_top.sv
`default_nettype none
// ********************************
// testbench
// ********************************
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import exec_pkg::*;
  logic        core_clk_i, rst_n_i, mem_rd_o, mem_wr_o;
  logic [15:0] mem_addr_o;
  logic [7:0]  mem_wdata_o, mem_rdata_i, s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0]  s_axi_wstrb;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic        s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  int          miscompares, total_checks;
  shift_branch_break_exec uut (
    .core_clk_i, .rst_n_i, .mem_addr_o, .mem_rd_o, .mem_wr_o, .mem_wdata_o, .mem_rdata_i,
    .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
    .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready
  );
  mem_model mem (.clk_i(core_clk_i), .addr_i(mem_addr_o), .rd_i(mem_rd_o), .wr_i(mem_wr_o),
    .wdata_i(mem_wdata_o), .rdata_o(mem_rdata_i));
  initial
  begin
    core_clk_i = 1'b0;
    forever #5 core_clk_i = ~core_clk_i;
  end
  task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string msg);
    total_checks++;
    if (got !== exp)
    begin
      $display("unexpected at %0t: %s", $time, msg);
      miscompares++;
    end
  endtask
  task automatic finish_test;
    $display("checks %0d mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    @(posedge core_clk_i);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do
    begin
      @(posedge core_clk_i);
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid);
    r = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge core_clk_i);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do
    begin
      @(posedge core_clk_i);
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid);
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask
  // every test restarts from reset; a trap loop sits at 0x30
  task automatic do_reset(input logic [255:0] v, input int n);
    rst_n_i <= 1'b0;
    repeat (16) @(posedge core_clk_i);
    rst_n_i <= 1'b1;
    mem.mem[16'h30] = 8'h80;
    mem.mem[16'h31] = 8'hfe;
    for (int i = 0; i < n; i++) mem.mem[i] = v[8*(n-1-i) +: 8];
  endtask
  // pc is polled with a bound, since the core runs on until halted
  task automatic poll(input logic [15:0] pc, output logic [31:0] d);
    logic [1:0] r;
    int         n;
    n = 0;
    do
    begin
      rd(REG_PC, d, r);
      n++;
    end while (d[15:0] !== pc && n < 300);
  endtask
  task automatic go(input logic [15:0] pc, output logic [31:0] st);
    logic [31:0] d;
    logic [1:0]  r;
    wr(REG_CTRL, 32'h1, r);
    poll(pc, d);
    wr(REG_CTRL, 32'h0, r);
    poll(pc, d);
    chk(d[15:0], pc, "final pc");
    rd(REG_STAT, st, r);
  endtask
  task automatic t_regs;
    logic [31:0] d;
    logic [1:0]  r;
    do_reset(256'h0, 0);
    rd(REG_STAT, d, r);
    chk(d[15:0], {SP_RESET, PS_RESET}, "stat reset");
    rd(REG_PC, d, r);
    chk(d[15:0], RESET_PC, "pc reset");
    wr(REG_ACC, 32'h55, r);
    chk(16'(r), 16'(RESP_ERR), "acc write accepted");
    rd(8'h10, d, r);
    chk(16'(r), 16'(RESP_ERR), "unmapped read accepted");
    chk(d[15:0], 16'h0, "unmapped data");
    $display("registers done");
  endtask
  task automatic t_shift;
    logic [31:0] st;
    do_reset(176'h0640_902c_b002_80fe_f026_d002_80fe_3020_1002_80fe_80fe, 22);
    mem.mem[16'h40] = 8'h81;
    go(16'h0014, st);
    chk(16'(mem.mem[16'h40]), 16'h0002, "shifted byte");
    chk(st[15:0], 16'hff05, "flags after shift");
    $display("shift and flag branches done");
  endtask
  task automatic t_bits;
    logic [31:0] st;
    do_reset(240'h0a0a_0a0a_0a0a_0a0a_2441_e324_f301_eaa7_4102_80fe_b741_19f0_03ea_eaea_80fe, 30);
    mem.mem[16'h41] = 8'h20;
    go(16'h001c, st);
    chk(16'(mem.mem[16'h41]), 16'h0020, "tested byte");
    chk(st[15:0] & 16'hfffe, 16'hff06, "flags after test");
    $display("bit branches done");
  endtask
  task automatic t_swi;
    logic [31:0] st;
    do_reset(56'h8004_eaea_eaea_00, 7);
    mem.mem[16'h20] = 8'h80;
    mem.mem[16'h21] = 8'hfe;
    mem.mem[SWI_VEC] = 8'h20;
    mem.mem[SWI_VEC + 16'h1] = 8'h00;
    go(16'h0020, st);
    chk(16'(mem.mem[16'h01ff]), 16'h0000, "pushed pc high");
    chk(16'(mem.mem[16'h01fe]), 16'h0008, "pushed pc low");
    chk(16'(mem.mem[16'h01fd]), 16'h0014, "pushed status");
    chk(st[15:0], 16'hfc14, "stack after interrupt");
    $display("software interrupt done");
  endtask
  initial
  begin
    rst_n_i = 1'b0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    s_axi_wstrb = 4'hf;
    miscompares = 0;
    total_checks = 0;
    t_regs();
    t_shift();
    t_bits();
    t_swi();
    finish_test();
  end
  initial
  begin
    repeat (90000) @(posedge core_clk_i);
    miscompares++;
    $display("unexpected at %0t: watchdog expired", $time);
    finish_test();
  end
endmodule // tb_top
`default_nettype wire
